//--- pkg/panel_monitor_pkg.sv
package panel_monitor_pkg;

  localparam int          NUM_AXES        = 2;
  localparam logic [4:0]  NUM_ITEMS       = 5'h11;
  localparam logic [4:0]  ITEM_SPEED      = 5'h00;
  localparam logic [4:0]  ITEM_ELEC_ANGLE = 5'h01;
  localparam logic [4:0]  CMD_PULSE_RATE_ITEM     = 5'h02;
  localparam logic [4:0]  ITEM_BUS_VOLT   = 5'h03;
  localparam logic [4:0]  ITEM_ANA_SPEED  = 5'h04;
  localparam logic [4:0]  ITEM_ANA_TORQUE = 5'h05;
  localparam logic [4:0]  TORQUE_CMD_ITEM         = 5'h06;
  localparam logic [4:0]  INPUT_STATE_ITEM        = 5'h07;
  localparam logic [4:0]  OUTPUT_STATE_ITEM       = 5'h08;
  localparam logic [4:0]  ENCODER_SIGNAL_ITEM     = 5'h09;
  localparam logic [4:0]  CMD_PULSE_COUNTER_ITEM  = 5'h0A;
  localparam logic [4:0]  FEEDBACK_COUNTER_ITEM   = 5'h0B;
  localparam logic [4:0]  POSITION_ERROR_ITEM     = 5'h0C;
  localparam logic [4:0]  ITEM_LOAD_RATE  = 5'h0D;
  localparam logic [4:0]  ITEM_INERTIA    = 5'h0E;
  localparam logic [4:0]  ENCODER_ANGLE_ITEM      = 5'h0F;
  localparam logic [4:0]  TURN_COUNT_ITEM         = 5'h10;

  // display character codes: 0..F are hex digits
  localparam logic [4:0]  CH_BLANK = 5'h10;
  localparam logic [4:0]  CH_U     = 5'h11;
  localparam logic [4:0]  CH_N     = 5'h12;
  localparam logic [4:0]  CH_LOW   = 5'h13;
  localparam logic [4:0]  CH_MID   = 5'h14;
  localparam logic [4:0]  CH_TOP   = 5'h15;

  // page of a 32-bit counter
  localparam logic [1:0]  PAGE_LOW = 2'h0;
  localparam logic [1:0]  PAGE_MID = 2'h1;
  localparam logic [1:0]  PAGE_TOP = 2'h2;

  // encoder monitor bit positions (bit 0 is display position 1)
  localparam int          ENC_BIT_A = 6;
  localparam int          ENC_BIT_B = 5;

  // pulse rate gate time, and its length in 4 ns cycles
  localparam int          CLK_MHZ       = 250;
  localparam int          RATE_GATE_US  = 1000;
  localparam int          RATE_GATE_CYC = RATE_GATE_US * CLK_MHZ;

  typedef enum logic [0:0] {
    ST_ITEM = 1'b0,
    ST_DATA = 1'b1
  } view_t;

  typedef struct packed {
    logic        up;
    logic        down;
    logic        set;
    logic        shift;
  } keys_t;

  typedef struct packed {
    logic [15:0] speed;
    logic [15:0] elec_angle;
    logic [15:0] bus_volt;
    logic [15:0] ana_speed;
    logic [15:0] ana_torque;
    logic [15:0] torque_pct;
    logic [15:0] torque_amps;
    logic [15:0] load_rate;
    logic [15:0] inertia;
    logic [15:0] turns;
    logic [31:0] pos_err;
    logic [31:0] enc_angle;
    logic        torque_in_amps;
    logic        pos_ctrl;
    logic        abs_enc;
    logic        incr_enc;
  } axis_live_t;

  typedef struct packed {
    logic [4:0]  ch4;
    logic [4:0]  ch3;
    logic [4:0]  ch2;
    logic [4:0]  ch1;
    logic [4:0]  ch0;
    logic [4:0]  dp;
    logic        bit_view;
    logic [7:0]  seg_upper;
    logic [7:0]  seg_lower;
    logic        item_valid;
  } disp_t;

endpackage

//--- hw/page_digits.sv
`timescale 1ns/1ns
module page_digits
  import panel_monitor_pkg::*;
(
  input  wire logic [31:0] value,
  input  wire logic        paged,
  input  wire logic [1:0]  page,
  output logic      [4:0]  d3,
  output logic      [4:0]  d2,
  output logic      [4:0]  d1,
  output logic      [4:0]  d0
);

  logic [15:0] sel;
  logic        top;

  // top page shows the sign extension of the counter as two digits
  always_comb begin
    top = paged && (page == PAGE_TOP);
    sel = value[15:0];
    if (paged && page == PAGE_MID) begin
      sel = value[31:16];
    end else if (top) begin
      sel = {8'h00, {8{value[31]}}};
    end
    d3 = top ? CH_BLANK : {1'b0, sel[15:12]};
    d2 = top ? CH_BLANK : {1'b0, sel[11:8]};
    d1 = {1'b0, sel[7:4]};
    d0 = {1'b0, sel[3:0]};
  end

endmodule

//--- hw/panel_monitor.sv
`timescale 1ns/1ns
module panel_monitor
  import panel_monitor_pkg::*;
#(
  parameter int RATE_GATE = RATE_GATE_CYC
)
(
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  input  wire logic                      ce,
  input  wire logic                      mon_active,
  input  wire keys_t                     keys,
  input  wire axis_live_t [NUM_AXES-1:0] live,
  input  wire logic [NUM_AXES-1:0]       cmd_pulse_pin,
  input  wire logic [NUM_AXES-1:0]       cmd_dir_pin,
  input  wire logic [NUM_AXES-1:0][7:0]  enc_pin,
  input  wire logic [7:0]                in_term_pin,
  input  wire logic [5:0]                out_term_state,
  output disp_t                          disp
);

  view_t                           view_ff;
  logic  [4:0]                     item_ff;
  logic                            axis_ff;
  logic  [1:0]                     page_ff;
  disp_t                           disp_ff;
  disp_t                           nxt_disp;

  logic  [NUM_AXES-1:0][7:0]       enc_s1_ff;
  logic  [NUM_AXES-1:0][7:0]       enc_s2_ff;
  logic  [NUM_AXES-1:0]            pls_s1_ff;
  logic  [NUM_AXES-1:0]            pls_s2_ff;
  logic  [NUM_AXES-1:0]            pls_d_ff;
  logic  [NUM_AXES-1:0]            dir_s1_ff;
  logic  [NUM_AXES-1:0]            dir_s2_ff;
  logic  [7:0]                     in_s1_ff;
  logic  [7:0]                     in_s2_ff;
  logic  [NUM_AXES-1:0][1:0]       quad_d_ff;
  logic  [NUM_AXES-1:0][31:0]      cmd_cnt_ff;
  logic  [NUM_AXES-1:0][31:0]      fb_cnt_ff;
  logic  [NUM_AXES-1:0][15:0]      rate_acc_ff;
  logic  [NUM_AXES-1:0][15:0]      rate_ff;
  logic  [31:0]                    gate_cnt_ff;
  logic                            gate_end;

  axis_live_t                      sel_live;
  logic  [31:0]                    sel_value;
  logic                            sel_paged;
  logic                            sel_valid;
  logic                            sel_bits;
  logic  [7:0]                     sel_upper;
  logic  [7:0]                     sel_lower;
  logic  [4:0]                     dg3;
  logic  [4:0]                     dg2;
  logic  [4:0]                     dg1;
  logic  [4:0]                     dg0;
  logic  [4:0]                     item_tens;
  logic  [4:0]                     item_units;

  assign disp = disp_ff;

  // pins are asynchronous to clk_sys: two flops before use
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      enc_s1_ff <= '0;
      enc_s2_ff <= '0;
      pls_s1_ff <= '0;
      pls_s2_ff <= '0;
      dir_s1_ff <= '0;
      dir_s2_ff <= '0;
      in_s1_ff  <= '0;
      in_s2_ff  <= '0;
    end else if (ce) begin
      enc_s1_ff <= enc_pin;
      enc_s2_ff <= enc_s1_ff;
      pls_s1_ff <= cmd_pulse_pin;
      pls_s2_ff <= pls_s1_ff;
      dir_s1_ff <= cmd_dir_pin;
      dir_s2_ff <= dir_s1_ff;
      in_s1_ff  <= in_term_pin;
      in_s2_ff  <= in_s1_ff;
    end
  end

  // shared gate timer for the pulse rate measurement
  assign gate_end = (gate_cnt_ff == 32'(RATE_GATE - 1));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gate_cnt_ff <= '0;
    end else if (ce) begin
      gate_cnt_ff <= gate_end ? '0 : gate_cnt_ff + 32'h0000_0001;
    end
  end

  for (genvar ax = 0; ax < NUM_AXES; ax++) begin : g_axis
    logic       pls_rise;
    logic [1:0] quad_now;
    logic       quad_step;
    logic       quad_up;

    assign pls_rise  = pls_s2_ff[ax] && !pls_d_ff[ax];
    assign quad_now  = {enc_s2_ff[ax][ENC_BIT_A], enc_s2_ff[ax][ENC_BIT_B]};
    assign quad_step = (quad_now != quad_d_ff[ax]) && (quad_now != ~quad_d_ff[ax]);
    // gray sequence 00,10,11,01 counts up
    assign quad_up   = (quad_d_ff[ax][1] ^ quad_now[0]) == 1'b0;

    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        pls_d_ff[ax]   <= 1'b0;
        cmd_cnt_ff[ax] <= '0;
      end else if (ce) begin
        pls_d_ff[ax] <= pls_s2_ff[ax];
        if (pls_rise && live[ax].pos_ctrl) begin
          // count wraps freely; software reads the difference
          cmd_cnt_ff[ax] <= dir_s2_ff[ax] ? cmd_cnt_ff[ax] - 32'h0000_0001
                                          : cmd_cnt_ff[ax] + 32'h0000_0001;
        end
      end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        rate_acc_ff[ax] <= '0;
        rate_ff[ax]     <= '0;
      end else if (ce) begin
        if (gate_end) begin
          // pulses per millisecond equals kilohertz
          rate_ff[ax]     <= rate_acc_ff[ax];
          rate_acc_ff[ax] <= {15'h0000, pls_rise};
        end else if (pls_rise && rate_acc_ff[ax] != 16'hFFFF) begin
          rate_acc_ff[ax] <= rate_acc_ff[ax] + 16'h0001;
        end
      end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        quad_d_ff[ax] <= '0;
        fb_cnt_ff[ax] <= '0;
      end else if (ce) begin
        quad_d_ff[ax] <= quad_now;
        // every edge of A or B counts; a double jump is a lost step, not counted
        if (quad_step) begin
          fb_cnt_ff[ax] <= quad_up ? fb_cnt_ff[ax] + 32'h0000_0001
                                   : fb_cnt_ff[ax] - 32'h0000_0001;
        end
      end
    end
  end

  // key handling; the block has no path to the drive, so browsing is harmless
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      view_ff <= ST_ITEM;
      item_ff <= ITEM_SPEED;
      axis_ff <= 1'b0;
      page_ff <= PAGE_LOW;
    end else if (ce) begin
      if (!mon_active) begin
        view_ff <= ST_ITEM;
        page_ff <= PAGE_LOW;
      end else begin
        case (view_ff)
          ST_ITEM: begin
            if (keys.set) begin
              view_ff <= ST_DATA;
              page_ff <= PAGE_LOW;
            end else if (keys.up) begin
              item_ff <= (item_ff == NUM_ITEMS - 5'h01) ? 5'h00 : item_ff + 5'h01;
            end else if (keys.down) begin
              item_ff <= (item_ff == 5'h00) ? NUM_ITEMS - 5'h01 : item_ff - 5'h01;
            end
          end
          ST_DATA: begin
            if (keys.set) begin
              view_ff <= ST_ITEM;
            end else if (keys.up || keys.down) begin
              axis_ff <= ~axis_ff;
            end else if (keys.shift && sel_paged) begin
              page_ff <= (page_ff == PAGE_TOP) ? PAGE_LOW : page_ff + 2'h1;
            end
          end
          default: begin
            view_ff <= ST_ITEM;
          end
        endcase
      end
    end
  end

  // value selection for the item and axis on show
  always_comb begin
    sel_live  = live[axis_ff];
    sel_value = '0;
    sel_paged = 1'b0;
    sel_valid = 1'b1;
    sel_bits  = 1'b0;
    sel_upper = '0;
    sel_lower = '0;
    case (item_ff)
      ITEM_SPEED: begin
        sel_value = {16'h0000, sel_live.speed};
      end
      ITEM_ELEC_ANGLE: begin
        sel_value = {16'h0000, sel_live.elec_angle};
      end
      CMD_PULSE_RATE_ITEM: begin
        sel_value = {16'h0000, rate_ff[axis_ff]};
        sel_valid = sel_live.pos_ctrl;
      end
      ITEM_BUS_VOLT: begin
        sel_value = {16'h0000, sel_live.bus_volt};
      end
      ITEM_ANA_SPEED: begin
        sel_value = {16'h0000, sel_live.ana_speed};
      end
      ITEM_ANA_TORQUE: begin
        sel_value = {16'h0000, sel_live.ana_torque};
      end
      TORQUE_CMD_ITEM: begin
        sel_value = sel_live.torque_in_amps ? {16'h0000, sel_live.torque_amps}
                                            : {16'h0000, sel_live.torque_pct};
      end
      INPUT_STATE_ITEM: begin
        sel_bits  = 1'b1;
        sel_upper = ~in_s2_ff;
        sel_lower = in_s2_ff;
      end
      OUTPUT_STATE_ITEM: begin
        sel_bits  = 1'b1;
        sel_upper = {2'b00, ~out_term_state};
        sel_lower = {2'b00, out_term_state};
      end
      ENCODER_SIGNAL_ITEM: begin
        sel_bits  = 1'b1;
        sel_valid = sel_live.incr_enc;
        sel_upper = ~enc_s2_ff[axis_ff];
        sel_lower = enc_s2_ff[axis_ff];
      end
      CMD_PULSE_COUNTER_ITEM: begin
        sel_value = cmd_cnt_ff[axis_ff];
        sel_paged = 1'b1;
        sel_valid = sel_live.pos_ctrl;
      end
      FEEDBACK_COUNTER_ITEM: begin
        sel_value = fb_cnt_ff[axis_ff];
        sel_paged = 1'b1;
      end
      POSITION_ERROR_ITEM: begin
        sel_value = sel_live.pos_err;
        sel_paged = 1'b1;
        sel_valid = sel_live.pos_ctrl;
      end
      ITEM_LOAD_RATE: begin
        sel_value = {16'h0000, sel_live.load_rate};
      end
      ITEM_INERTIA: begin
        sel_value = {16'h0000, sel_live.inertia};
      end
      ENCODER_ANGLE_ITEM: begin
        sel_value = sel_live.enc_angle;
        sel_paged = 1'b1;
      end
      TURN_COUNT_ITEM: begin
        sel_value = {16'h0000, sel_live.turns};
        sel_valid = sel_live.abs_enc;
      end
      default: begin
        sel_valid = 1'b0;
      end
    endcase
  end

  page_digits u_page_digits (
    .value (sel_value),
    .paged (sel_paged),
    .page  (page_ff),
    .d3    (dg3),
    .d2    (dg2),
    .d1    (dg1),
    .d0    (dg0)
  );

  // item number is at most 16, so tens is 0 or 1
  assign item_tens  = (item_ff >= 5'h0A) ? 5'h01 : 5'h00;
  assign item_units = (item_ff >= 5'h0A) ? item_ff - 5'h0A : item_ff;

  always_comb begin
    nxt_disp            = '0;
    nxt_disp.item_valid = sel_valid;
    if (view_ff == ST_ITEM) begin
      nxt_disp.ch4 = CH_U;
      nxt_disp.ch3 = CH_N;
      nxt_disp.ch2 = 5'h00;
      nxt_disp.ch1 = item_tens;
      nxt_disp.ch0 = item_units;
    end else if (!sel_valid) begin
      // invalid items show dashes rather than stale numbers
      nxt_disp.ch4 = CH_MID;
      nxt_disp.ch3 = CH_MID;
      nxt_disp.ch2 = CH_MID;
      nxt_disp.ch1 = CH_MID;
      nxt_disp.ch0 = CH_MID;
      nxt_disp.dp  = {4'h0, axis_ff};
    end else if (sel_bits) begin
      nxt_disp.ch4       = CH_BLANK;
      nxt_disp.ch3       = CH_BLANK;
      nxt_disp.ch2       = CH_BLANK;
      nxt_disp.ch1       = CH_BLANK;
      nxt_disp.ch0       = CH_BLANK;
      nxt_disp.bit_view  = 1'b1;
      nxt_disp.seg_upper = sel_upper;
      nxt_disp.seg_lower = sel_lower;
      nxt_disp.dp        = {4'h0, axis_ff};
    end else begin
      nxt_disp.ch4 = !sel_paged ? CH_BLANK :
                     (page_ff == PAGE_LOW) ? CH_LOW :
                     (page_ff == PAGE_MID) ? CH_MID : CH_TOP;
      nxt_disp.ch3 = dg3;
      nxt_disp.ch2 = dg2;
      nxt_disp.ch1 = dg1;
      nxt_disp.ch0 = dg0;
      nxt_disp.dp  = {4'h0, axis_ff};
    end
  end

  // registered every enabled cycle so the shown value tracks the live one
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      disp_ff <= '0;
    end else if (ce) begin
      disp_ff <= nxt_disp;
    end
  end

endmodule

//--- tb/panel_operator.sv
`timescale 1ns/1ns
module panel_operator
  import panel_monitor_pkg::*;
(
  input  wire logic clk_sys,
  output keys_t     keys
);
  initial keys = '0;
  // one debounced key, one cycle wide, then idle so the display settles before the next
  task automatic press(input keys_t k);
    @(negedge clk_sys);
    keys = k;
    @(negedge clk_sys);
    keys = '0;
    repeat (3) @(negedge clk_sys);
  endtask
endmodule

//--- tb/panel_monitor_checker.sv
`timescale 1ns/1ns
module panel_monitor_checker
  import panel_monitor_pkg::*;
#(
  parameter int RATE_GATE = RATE_GATE_CYC
)
(
  input  wire logic  clk_sys,
  input  wire logic  rst_b,
  input  wire logic  ce,
  input  wire logic  mon_active,
  input  wire keys_t keys,
  input  wire disp_t disp
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // a key is judged only when no earlier key is still on its way to the display
  sequence s_key_taken;
    ce && mon_active && $past(keys) == 4'h0;
  endsequence
  sequence s_item_view;
    disp.ch4 == CH_U && disp.ch3 == CH_N;
  endsequence
  sequence s_shift_at(logic [4:0] mark);
    disp.ch4 == mark && disp.item_valid && keys.shift ##0 s_key_taken;
  endsequence
  a_set_opens_data: assert property (s_item_view ##0 keys.set ##0 s_key_taken |-> ##2
    disp.ch4 != CH_U) else $error("set did not open data view");
  a_set_back_item: assert property (disp.ch4 != CH_U && keys.set ##0 s_key_taken |-> ##2
    s_item_view) else $error("set did not return to item number");
  a_shift_item_kept: assert property (s_item_view ##0 keys.shift ##0 s_key_taken |-> ##2
    disp.ch2 == $past(disp.ch2, 2) && disp.ch1 == $past(disp.ch1, 2)
    && disp.ch0 == $past(disp.ch0, 2)) else $error("shift changed item view");
  a_page_low_mid: assert property (s_shift_at(CH_LOW) |-> ##2 disp.ch4 == CH_MID)
    else $error("low page did not step to middle");
  a_page_mid_top: assert property (s_shift_at(CH_MID) |-> ##2 disp.ch4 == CH_TOP)
    else $error("middle page did not step to top");
  a_page_top_low: assert property (s_shift_at(CH_TOP) |-> ##2 disp.ch4 == CH_LOW)
    else $error("top page did not wrap to low");
  a_axis_toggle: assert property (disp.ch4 != CH_U && (keys.up || keys.down)
    ##0 s_key_taken |-> ##2 disp.dp[0] != $past(disp.dp[0], 2))
    else $error("axis mark did not toggle");
  a_bit_complement: assert property (disp.bit_view |->
    disp.seg_upper[5:0] == ~disp.seg_lower[5:0]) else $error("segments not complementary");
  a_invalid_dashes: assert property ($past(rst_b) && !disp.item_valid && !disp.bit_view
    && disp.ch4 != CH_U |-> disp.ch0 == CH_MID && disp.ch2 == CH_MID && disp.ch4 == CH_MID)
    else $error("invalid item not dashed");
endmodule
bind panel_monitor panel_monitor_checker #(.RATE_GATE(RATE_GATE)) i_chk (.clk_sys(clk_sys),
  .rst_b(rst_b), .ce(ce), .mon_active(mon_active), .keys(keys), .disp(disp));

//--- tb/tb.sv
`timescale 1ns/1ns
module tb
  import panel_monitor_pkg::*;
;
  typedef struct packed {logic [4:0] item; logic axis; logic [15:0] exp;} row_t;
  localparam keys_t K_UP = 4'h8;
  localparam keys_t K_DOWN = 4'h4;
  localparam keys_t K_SET = 4'h2;
  localparam keys_t K_SHIFT = 4'h1;
  localparam row_t ROWS [10] = '{'{5'h00, 1'b0, 16'h2000}, '{5'h01, 1'b0, 16'h2100},
    '{5'h03, 1'b1, 16'h2301}, '{5'h04, 1'b0, 16'h2400}, '{5'h05, 1'b1, 16'h2501},
    '{5'h06, 1'b0, 16'h2600}, '{5'h06, 1'b1, 16'h2601}, '{5'h0D, 1'b0, 16'h2D00},
    '{5'h0E, 1'b1, 16'h2E01}, '{5'h10, 1'b0, 16'h3000}};
  logic                        clk_sys = 1'b0;
  logic                        rst_b = 1'b0;
  logic                        ce = 1'b1;
  logic                        mon_active = 1'b1;
  keys_t                       keys;
  axis_live_t [NUM_AXES-1:0]   live;
  logic [NUM_AXES-1:0]         cmd_pulse_pin = '0;
  logic [NUM_AXES-1:0]         cmd_dir_pin = '0;
  logic [NUM_AXES-1:0][7:0]    enc_pin = '0;
  logic [7:0]                  in_term_pin = 8'h00;
  logic [5:0]                  out_term_state = 6'h00;
  disp_t                       disp;
  int                          miscompares = 0;
  int                          n_checks = 0;
  logic [4:0]                  cur_item = 5'h00;
  logic                        cur_axis = 1'b0;
  always #2 clk_sys = ~clk_sys;
  panel_operator i_op (.clk_sys(clk_sys), .keys(keys));
  panel_monitor #(.RATE_GATE(50)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .mon_active(mon_active), .keys(keys), .live(live), .cmd_pulse_pin(cmd_pulse_pin),
    .cmd_dir_pin(cmd_dir_pin), .enc_pin(enc_pin), .in_term_pin(in_term_pin),
    .out_term_state(out_term_state), .disp(disp));
  function automatic logic [15:0] v(input logic [4:0] item, input logic a);
    return {3'b001, item, 4'h0, 3'b000, a};
  endfunction
  task automatic complete_run;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chv(input logic [15:0] e);
    chk(48'({disp.ch3, disp.ch2, disp.ch1, disp.ch0}),
        48'({1'b0, e[15:12], 1'b0, e[11:8], 1'b0, e[7:4], 1'b0, e[3:0]}));
  endtask
  task automatic goto(input logic [4:0] item);
    while (cur_item != item) begin
      i_op.press(K_UP);
      cur_item = (cur_item == 5'h10) ? 5'h00 : cur_item + 5'h01;
    end
  endtask
  task automatic open_data(input logic axis);
    i_op.press(K_SET);
    if (cur_axis != axis) begin
      i_op.press(K_UP);
      cur_axis = axis;
    end
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      cmd_pulse_pin[0] = 1'b1;
      repeat (2) @(negedge clk_sys);
      cmd_pulse_pin[0] = 1'b0;
      repeat (3) @(negedge clk_sys);
    end
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic qstep(input logic [1:0] ab);
    enc_pin[0][6:5] = ab;
    repeat (4) @(negedge clk_sys);
  endtask
  initial begin
    for (int a = 0; a < NUM_AXES; a++) begin
      live[a] = '0;
      live[a].speed = v(5'h00, a[0]);
      live[a].elec_angle = v(5'h01, a[0]);
      live[a].bus_volt = v(5'h03, a[0]);
      live[a].ana_speed = v(5'h04, a[0]);
      live[a].ana_torque = v(5'h05, a[0]);
      live[a].load_rate = v(5'h0D, a[0]);
      live[a].inertia = v(5'h0E, a[0]);
      live[a].turns = v(5'h10, a[0]);
      // the unit not selected carries a value that must never show
      live[a].torque_pct = a[0] ? 16'hFFFF : v(5'h06, 1'b0);
      live[a].torque_amps = a[0] ? v(5'h06, 1'b1) : 16'hFFFF;
      live[a].torque_in_amps = a[0];
      live[a].abs_enc = 1'b1;
      live[a].incr_enc = 1'b1;
    end
    live[0].enc_angle = 32'h89AB_CDEF;
    live[0].pos_err = 32'h0012_3456;
    repeat (10) @(negedge clk_sys);
    chk(48'(disp), 48'h0);
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(48'({disp.ch4, disp.ch3, disp.ch0}), 48'({CH_U, CH_N, 5'h00}));
    i_op.press(K_SHIFT);
    chk(48'(disp.ch4), 48'(CH_U));
    foreach (ROWS[i]) begin
      goto(ROWS[i].item);
      open_data(ROWS[i].axis);
      chv(ROWS[i].exp);
      chk(48'(disp.dp[0]), 48'(ROWS[i].axis));
      i_op.press(K_SET);
    end
    open_data(1'b0);
    live[0].turns = 16'hBEEF;
    repeat (3) @(negedge clk_sys);
    chv(16'hBEEF);
    ce = 1'b0;
    i_op.press(K_UP);
    ce = 1'b1;
    chk(48'(disp.dp[0]), 48'h0);
    live[0].abs_enc = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(48'(disp.item_valid), 48'h0);
    i_op.press(K_SET);
    goto(5'h0F);
    open_data(1'b0);
    chk(48'(disp.ch4), 48'(CH_LOW));
    chv(16'hCDEF);
    i_op.press(K_SHIFT);
    chk(48'(disp.ch4), 48'(CH_MID));
    chv(16'h89AB);
    i_op.press(K_SHIFT);
    chk(48'(disp.ch4), 48'(CH_TOP));
    chk(48'({disp.ch3, disp.ch2, disp.ch1, disp.ch0}), 48'({CH_BLANK, CH_BLANK, 5'h0F, 5'h0F}));
    i_op.press(K_SHIFT);
    chv(16'hCDEF);
    i_op.press(K_SET);
    goto(5'h0C);
    open_data(1'b0);
    chk(48'({disp.ch4, disp.ch2, disp.ch0}), 48'({CH_MID, CH_MID, CH_MID}));
    live[0].pos_ctrl = 1'b1;
    repeat (3) @(negedge clk_sys);
    chv(16'h3456);
    i_op.press(K_SET);
    goto(5'h02);
    open_data(1'b0);
    // pulse period divides the gate, so every full window holds exactly ten
    fork
      pulses(40);
      begin
        repeat (150) @(negedge clk_sys);
        chv(16'h000A);
      end
    join
    i_op.press(K_SET);
    goto(5'h0A);
    open_data(1'b0);
    chv(16'h0028);
    cmd_dir_pin[0] = 1'b1;
    repeat (4) @(negedge clk_sys);
    pulses(3);
    live[0].pos_ctrl = 1'b0;
    pulses(2);
    live[0].pos_ctrl = 1'b1;
    // axis B must be in position control too, or its counter shows dashes
    live[1].pos_ctrl = 1'b1;
    repeat (2) @(negedge clk_sys);
    chv(16'h0025);
    i_op.press(K_UP);
    cur_axis = 1'b1;
    chv(16'h0000);
    i_op.press(K_SET);
    goto(5'h0B);
    open_data(1'b0);
    repeat (2) begin
      qstep(2'b10);
      qstep(2'b11);
      qstep(2'b01);
      qstep(2'b00);
    end
    qstep(2'b01);
    repeat (4) @(negedge clk_sys);
    chv(16'h0007);
    i_op.press(K_SET);
    goto(5'h07);
    in_term_pin = 8'h3C;
    open_data(1'b0);
    chk(48'({disp.bit_view, disp.seg_upper, disp.seg_lower}), 48'h1_C33C);
    i_op.press(K_SET);
    goto(5'h08);
    out_term_state = 6'h25;
    open_data(1'b0);
    chk(48'({disp.seg_upper, disp.seg_lower}), 48'h1A25);
    i_op.press(K_SET);
    goto(5'h09);
    enc_pin[0] = 8'h5A;
    open_data(1'b0);
    chk(48'({disp.seg_upper, disp.seg_lower}), 48'hA55A);
    live[0].incr_enc = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(48'(disp.item_valid), 48'h0);
    mon_active = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(48'({disp.ch4, disp.ch0}), 48'({CH_U, 5'h09}));
    i_op.press(K_SET);
    chk(48'(disp.ch4), 48'(CH_U));
    mon_active = 1'b1;
    i_op.press(K_DOWN);
    chk(48'(disp.ch0), 48'h8);
    i_op.press(K_SET);
    i_op.press(K_DOWN);
    chk(48'(disp.dp[0]), 48'h1);
    // a reset mid-run must put item, view and axis back to their start
    rst_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(48'(disp), 48'h0);
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(48'({disp.ch4, disp.ch0}), 48'({CH_U, 5'h00}));
    i_op.press(K_SET);
    chk(48'(disp.dp[0]), 48'h0);
    chv(v(5'h00, 1'b0));
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end
endmodule
